// ---- rtl/fsp_frame_stats.sv ----
// per-frame brightness total and darkest pixel engine
// assumes frame_start pulses before the first pixel and frame_end after the last
`timescale 1ns/100ps
`default_nettype none
module fsp_frame_stats (
  input  wire logic   clk,
  input  wire logic   rst,
  fsp_stats_if.stats  sif
);

  logic [fsp_pkg::ACC_W-1:0] acc_q,     acc_d;
  logic [fsp_pkg::PIX_W-1:0] run_min_q, run_min_d;
  logic [7:0]                sum_q;
  logic [fsp_pkg::PIX_W-1:0] min_q;

  // ************************************************************
  // running accumulation
  // ************************************************************
  // power-down freezes the running values so the last frame stays visible
  assign acc_d = sif.frame_start ? '0 :
                 (sif.pix_valid ? acc_q + {{(fsp_pkg::ACC_W-fsp_pkg::PIX_W){1'b0}},
                                           sif.pix_data} : acc_q);
  assign run_min_d = sif.frame_start ? fsp_pkg::PIX_MAX :
                     ((sif.pix_valid && sif.pix_data < run_min_q) ? sif.pix_data
                                                                  : run_min_q); // RULE1

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q     <= '0;
      run_min_q <= fsp_pkg::PIX_MAX;
    end else if (sif.enable) begin
      acc_q     <= acc_d;
      run_min_q <= run_min_d;
    end
  end

  // latch results at frame end; only bits 14:7 of the total are kept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sum_q <= 8'h00;
      min_q <= 7'h00;
    end else if (sif.enable && sif.frame_end) begin
      sum_q <= acc_q[fsp_pkg::SUM_MSB:fsp_pkg::SUM_LSB];
      min_q <= run_min_q; // RULE2
    end
  end

  assign sif.sum_hi  = sum_q;
  assign sif.min_val = min_q;

  // ************************************************************
  // checks
  // ************************************************************
  property p_min_refresh;
    @(posedge clk) disable iff (rst)
    (sif.enable && sif.frame_end) |=> (min_q == $past(run_min_q));
  endproperty
  a_min_refresh: assert property (p_min_refresh) else $error("darkest not refreshed"); // RULE2

  property p_min_tracks;
    @(posedge clk) disable iff (rst)
    (sif.enable && sif.pix_valid && !sif.frame_start) |=> (run_min_q <= $past(sif.pix_data));
  endproperty
  a_min_tracks: assert property (p_min_tracks) else $error("running min above a pixel"); // RULE1

  c_frame_done: cover property (@(posedge clk) disable iff (rst) sif.enable && sif.frame_end);

endmodule // fsp_frame_stats
`default_nettype wire

// ---- rtl/fsp_pixel_grab_top.sv ----
// register-level readout: frame statistics, one-pixel-per-frame grabber, control
// assumes a synchronous register port (one-cycle read/write strobes) and a pixel stream
// Operation
// RULE1 - darkest pixel of the frame is reported as a value 0 to 127
// RULE2 - darkest pixel statistic is refreshed at the end of every frame
// RULE3 - grabber latches at most one pixel per frame, the one at the index
// RULE4 - reading a valid grabbed pixel returns it with the top bit set
// RULE5 - valid read advances the pixel index and re-arms for a later frame
// RULE6 - the controller reads 361 valid pixels to collect one whole image
// RULE7 - any write to the grab register resets the index and arms for pixel 0
// RULE8 - grab register is eight bits: valid flag on top, pixel below
// RULE9 - control bit 1 set means power-down; frame capture halts until cleared
// RULE10 - control bit 0 picks 500 cpi when clear, 1000 cpi when set
`timescale 1ns/100ps
`default_nettype none
module fsp_pixel_grab_top #(
  parameter int IMAGE_PIX = fsp_pkg::IMAGE_PIX
) (
  input  wire logic                      CORE_CLK,
  input  wire logic                      SYS_RST,
  input  wire logic [6:0]                REG_ADDR,
  input  wire logic                      REG_WR,
  input  wire logic                      REG_RD,
  input  wire logic [7:0]                REG_WDATA,
  output var  logic [7:0]                REG_RDATA,
  output var  logic                      REG_RVALID,
  input  wire logic                      FRAME_START,
  input  wire logic                      PIX_VALID,
  input  wire logic [fsp_pkg::PIX_W-1:0] PIX_DATA,
  input  wire logic                      FRAME_END,
  output var  logic                      CAPTURE_EN,
  output var  logic                      CPI_1000
);

  localparam logic [fsp_pkg::IDX_W-1:0] LAST_IDX = fsp_pkg::IDX_W'(IMAGE_PIX - 1);

  fsp_stats_if                 sif ();
  fsp_pkg::fsp_grab_state_t    st_q, st_d;
  logic [fsp_pkg::IDX_W-1:0]   idx_q, idx_d;
  logic [fsp_pkg::IDX_W-1:0]   pos_q;
  logic [fsp_pkg::PIX_W-1:0]   grab_q;
  logic [7:0]                  ctrl_q, ctrl_d;
  logic [7:0]                  rdata_d;
  logic                        run;
  logic                        grab_wr, grab_rd, ctrl_wr, hit, grab_full;

  // ************************************************************
  // stats engine
  // ************************************************************
  // power-down stops the stream from reaching the statistics
  assign run             = !ctrl_q[fsp_pkg::SLEEP_SEL_POS]; // RULE9
  assign sif.frame_start = FRAME_START;
  assign sif.pix_valid   = PIX_VALID;
  assign sif.pix_data    = PIX_DATA;
  assign sif.frame_end   = FRAME_END;
  assign sif.enable      = run;

  fsp_frame_stats u_stats (
    .clk (CORE_CLK),
    .rst (SYS_RST),
    .sif (sif)
  );

  // ************************************************************
  // register decode
  // ************************************************************
  assign grab_wr = REG_WR && (REG_ADDR == fsp_pkg::ADDR_SAMPLE_GRAB);
  assign grab_rd = REG_RD && (REG_ADDR == fsp_pkg::ADDR_SAMPLE_GRAB) && !grab_wr;
  assign ctrl_wr = REG_WR && (REG_ADDR == fsp_pkg::ADDR_SENSE_CTRL);
  assign ctrl_d  = ctrl_wr ? (REG_WDATA & fsp_pkg::CTRL_WR_MASK) : ctrl_q;
  // grabber holds a pixel nobody has read yet
  assign grab_full = (st_q == fsp_pkg::GR_FULL);

  // read mux; reserved and unmapped addresses read zero
  assign rdata_d =
    (REG_ADDR == fsp_pkg::ADDR_BRIGHT_TOTAL) ? sif.sum_hi :
    (REG_ADDR == fsp_pkg::ADDR_DARKEST)      ? {1'b0, sif.min_val} : // RULE1
    (REG_ADDR == fsp_pkg::ADDR_SAMPLE_GRAB)  ? {grab_full, grab_q} : // RULE4 RULE8
    (REG_ADDR == fsp_pkg::ADDR_SENSE_CTRL)   ? ctrl_q : 8'h00;

  // ************************************************************
  // grabber sequencing
  // ************************************************************
  // hit: the pixel now on the stream is the one the index asks for
  assign hit = run && PIX_VALID && (pos_q == idx_q);

  always_comb begin
    st_d  = st_q;
    idx_d = idx_q;
    unique case (st_q)
      fsp_pkg::GR_WAIT_FRAME: if (run && FRAME_START) st_d = fsp_pkg::GR_HUNT;
      fsp_pkg::GR_HUNT: begin
        if (hit) st_d = fsp_pkg::GR_FULL; // RULE3
        else if (FRAME_END || !run) st_d = fsp_pkg::GR_WAIT_FRAME;
      end
      fsp_pkg::GR_FULL: begin
        // a full grabber ignores later frames until it is read
        if (grab_rd) begin
          st_d  = fsp_pkg::GR_WAIT_FRAME; // RULE5
          idx_d = (idx_q == LAST_IDX) ? '0 : idx_q + 1'b1; // RULE5 RULE6
        end
      end
    endcase
    // a write beats everything, including a read in the same cycle
    if (grab_wr) begin
      st_d  = fsp_pkg::GR_WAIT_FRAME; // RULE7
      idx_d = '0; // RULE7
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q  <= fsp_pkg::GR_WAIT_FRAME;
      idx_q <= '0;
    end else begin
      st_q  <= st_d;
      idx_q <= idx_d;
    end
  end

  // pixel position within the frame and the latched sample
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pos_q  <= '0;
      grab_q <= 7'h00;
    end else begin
      if (FRAME_START) pos_q <= '0;
      else if (PIX_VALID) pos_q <= pos_q + 1'b1;
      if (st_q == fsp_pkg::GR_HUNT && hit) grab_q <= PIX_DATA; // RULE3
    end
  end

  // ************************************************************
  // control and read port
  // ************************************************************
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_q     <= fsp_pkg::CTRL_RESET;
      CAPTURE_EN <= 1'b1;
      CPI_1000   <= 1'b0;
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      CAPTURE_EN <= !ctrl_d[fsp_pkg::SLEEP_SEL_POS]; // RULE9
      CPI_1000   <= ctrl_d[fsp_pkg::DENSITY_SEL_POS]; // RULE10
      REG_RVALID <= REG_RD;
      if (REG_RD) REG_RDATA <= rdata_d;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  property p_grab_holds;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (grab_full && !grab_rd && !grab_wr) |=> (grab_full && $stable(grab_q));
  endproperty
  a_grab_holds: assert property (p_grab_holds) else $error("grabbed pixel lost"); // RULE3

  property p_valid_read;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (grab_rd && grab_full) |=> (REG_RDATA == {1'b1, $past(grab_q)} && REG_RVALID);
  endproperty
  a_valid_read: assert property (p_valid_read) else $error("valid grab read wrong"); // RULE4

  property p_empty_read;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (grab_rd && !grab_full) |=> !REG_RDATA[fsp_pkg::GRAB_VALID_POS];
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty grab flagged valid"); // RULE8

  property p_advance;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (grab_rd && grab_full && idx_q != LAST_IDX)
      |=> (idx_q == $past(idx_q) + 1'b1 && st_q == fsp_pkg::GR_WAIT_FRAME);
  endproperty
  a_advance: assert property (p_advance) else $error("index not advanced"); // RULE5

  property p_wrap;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (grab_rd && grab_full && idx_q == LAST_IDX) |=> (idx_q == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("index did not wrap"); // RULE6

  property p_rearm;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    grab_wr |=> (idx_q == '0 && st_q == fsp_pkg::GR_WAIT_FRAME);
  endproperty
  a_rearm: assert property (p_rearm) else $error("write did not re-arm"); // RULE7

  property p_sleep;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    (ctrl_q[fsp_pkg::SLEEP_SEL_POS] && !ctrl_wr && !grab_full)
      |=> (st_q == fsp_pkg::GR_WAIT_FRAME && !CAPTURE_EN);
  endproperty
  a_sleep: assert property (p_sleep) else $error("capture during power-down"); // RULE9

  property p_density;
    @(posedge CORE_CLK) disable iff (SYS_RST)
    ctrl_wr |=> (CPI_1000 == $past(REG_WDATA[fsp_pkg::DENSITY_SEL_POS]));
  endproperty
  a_density: assert property (p_density) else $error("cpi select mismatch"); // RULE10

  c_grab_valid: cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
                                grab_rd && grab_full);
  c_wrap:       cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
                                grab_rd && grab_full && idx_q == LAST_IDX);
  c_sleep:      cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
                                ctrl_wr && REG_WDATA[fsp_pkg::SLEEP_SEL_POS]);

endmodule // fsp_pixel_grab_top
`default_nettype wire

// ---- rtl/fsp_pkg.sv ----
// constants shared by the frame statistics and pixel grab logic
// assumes a register port of 7-bit addresses and 8-bit data
package fsp_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [6:0] ADDR_BRIGHT_TOTAL = 7'h09;
  localparam logic [6:0] ADDR_DARKEST      = 7'h0a;
  localparam logic [6:0] ADDR_SAMPLE_GRAB  = 7'h0b;
  localparam logic [6:0] ADDR_RSVD_C       = 7'h0c;
  localparam logic [6:0] ADDR_SENSE_CTRL   = 7'h0d;

  // ************************************************************
  // field layout and reset values
  // ************************************************************
  localparam int         GRAB_VALID_POS  = 7;
  localparam int         SLEEP_SEL_POS   = 1;
  localparam int         DENSITY_SEL_POS = 0;
  localparam logic [7:0] CTRL_WR_MASK    = 8'h03;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam logic [7:0] GRAB_RESET      = 8'h00;
  localparam int         SUM_LSB         = 7;
  localparam int         SUM_MSB         = 14;

  // ************************************************************
  // image geometry
  // ************************************************************
  localparam int         PIX_W       = 7;
  localparam logic [6:0] PIX_MAX     = 7'h7f;
  localparam int         IMAGE_PIX   = 361;
  localparam int         IDX_W       = 9;
  localparam int         ACC_W       = 16;

  typedef enum logic [1:0] {
    GR_WAIT_FRAME,
    GR_HUNT,
    GR_FULL
  } fsp_grab_state_t;

endpackage

// ---- rtl/fsp_stats_if.sv ----
// pixel stream and frame statistics between the readout top and the stats engine
// assumes one clock shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface fsp_stats_if;
  logic                      frame_start;
  logic                      pix_valid;
  logic [fsp_pkg::PIX_W-1:0] pix_data;
  logic                      frame_end;
  logic                      enable;
  logic [7:0]                sum_hi;
  logic [fsp_pkg::PIX_W-1:0] min_val;

  modport stats (input frame_start, pix_valid, pix_data, frame_end, enable,
                 output sum_hi, min_val);
  modport host (output frame_start, pix_valid, pix_data, frame_end, enable,
                input sum_hi, min_val);
endinterface
`default_nettype wire

// ---- sim/fsp_ctrl_model.sv ----
// controller model: master of the register port of the readout block
// assumes one shared clock and one request at a time from the bench
`timescale 1ns/100ps
`default_nettype none
module fsp_ctrl_model (
  input  wire logic       clk,
  output var  logic [6:0] reg_addr,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // idle port at time zero
  initial begin
    reg_addr  = 7'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end
  // one-cycle write; idle lines are inverted so a stale value never helps
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  // one-cycle read; answer taken at the edge after the strobe
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule // fsp_ctrl_model
`default_nettype wire

// ---- sim/fsp_pixel_grab_top_tb.sv ----
// self-checking bench for the readout block: registers, statistics, grabber
// assumes fsp_ctrl_model as register master; the bench plays the pixel stream
`timescale 1ns/100ps
`default_nettype none
module fsp_pixel_grab_top_tb;
  localparam int IMG = 4; // short image so the index wrap is reached quickly
  typedef struct packed {
    logic [6:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic       cap;
    logic       cpi;
  } fsp_tbrow_t;
  logic       core_clk = 1'b0;
  logic       sys_rst, frame_start, pix_valid, frame_end;
  logic [6:0] pix_data, reg_addr;
  logic [7:0] reg_wdata, reg_rdata, got;
  logic       reg_wr, reg_rd, reg_rvalid, capture_en, cpi_1000, gv;
  int         bad_count = 0;
  int         total_checks = 0;
  int         cycles = 0;
  fsp_tbrow_t rows [6] = '{'{7'h0d, 8'h01, 8'h01, 1'b1, 1'b1},
                           '{7'h0d, 8'h02, 8'h02, 1'b0, 1'b0},
                           '{7'h0d, 8'hfe, 8'h02, 1'b0, 1'b0},
                           '{7'h0d, 8'h00, 8'h00, 1'b1, 1'b0},
                           '{7'h0c, 8'h55, 8'h00, 1'b1, 1'b0},
                           '{7'h09, 8'hff, 8'h00, 1'b1, 1'b0}};

  fsp_ctrl_model i_fsp_ctrl_model (.clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  fsp_pixel_grab_top #(.IMAGE_PIX(IMG)) i_fsp_pixel_grab_top (.CORE_CLK(core_clk),
    .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid),
    .FRAME_START(frame_start), .PIX_VALID(pix_valid), .PIX_DATA(pix_data),
    .FRAME_END(frame_end), .CAPTURE_EN(capture_en), .CPI_1000(cpi_1000));

  // 20 MHz clock
  always #25 core_clk = ~core_clk;
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      stop_test();
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [6:0] pv(input int b, input int i);
    return 7'((b * 37 + i * 53 + 40) % 128);
  endfunction
  function automatic logic [7:0] esum(input int b);
    int s;
    s = 0;
    for (int i = 0; i < IMG; i++) s += pv(b, i);
    return 8'(s >> 7);
  endfunction
  function automatic logic [7:0] emin(input int b);
    logic [6:0] m;
    m = 7'h7f;
    for (int i = 0; i < IMG; i++) if (pv(b, i) < m) m = pv(b, i);
    return {1'b0, m};
  endfunction
  // one frame: start pulse, IMG pixels, end pulse, one idle cycle
  task automatic frame(input int b);
    @(posedge core_clk);
    frame_start <= 1'b1;
    for (int i = 0; i < IMG; i++) begin
      @(posedge core_clk);
      frame_start <= 1'b0;
      pix_valid   <= 1'b1;
      pix_data    <= pv(b, i);
    end
    @(posedge core_clk);
    pix_valid <= 1'b0;
    pix_data  <= ~pix_data;
    frame_end <= 1'b1;
    @(posedge core_clk);
    frame_end <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    i_fsp_ctrl_model.rd(a, got, gv);
    chk({7'h00, gv}, 8'h01);
    chk(got, e);
  endtask
  task automatic stop_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    sys_rst     = 1'b1;
    frame_start = 1'b0;
    pix_valid   = 1'b0;
    frame_end   = 1'b0;
    pix_data    = 7'h00;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    rdc(7'h0b, 8'h00);
    rdc(7'h0d, 8'h00);
    chk({6'h00, capture_en, cpi_1000}, 8'h02);
    foreach (rows[k]) begin
      i_fsp_ctrl_model.wr(rows[k].a, rows[k].d);
      rdc(rows[k].a, rows[k].e);
      chk({6'h00, capture_en, cpi_1000}, {6'h00, rows[k].cap, rows[k].cpi});
    end
    rdc(7'h7f, 8'h00);
    frame(1);
    rdc(7'h09, esum(1));
    rdc(7'h0a, emin(1));
    frame(2);
    rdc(7'h0a, emin(2));
    // collect a whole image and wrap to pixel 0, one frame per pixel
    i_fsp_ctrl_model.wr(7'h0b, 8'h5a);
    for (int k = 0; k <= IMG; k++) begin
      frame(10 + k);
      rdc(7'h0b, {1'b1, pv(10 + k, k % IMG)});
    end
    rdc(7'h0b, {1'b0, pv(14, 0)});
    // two frames without a read: the first grab must stay
    frame(20);
    frame(21);
    rdc(7'h0b, {1'b1, pv(20, 1)});
    i_fsp_ctrl_model.wr(7'h0b, 8'h00);
    frame(23);
    rdc(7'h0b, {1'b1, pv(23, 0)});
    // power-down freezes statistics and grabber
    i_fsp_ctrl_model.wr(7'h0d, 8'h02);
    // the select flop is launched by the edge the write returns on; look once it settles
    @(negedge core_clk);
    chk({7'h00, capture_en}, 8'h00);
    frame(30);
    rdc(7'h0a, emin(23));
    rdc(7'h0b, {1'b0, pv(23, 0)});
    i_fsp_ctrl_model.wr(7'h0d, 8'h00);
    frame(31);
    rdc(7'h0b, {1'b1, pv(31, 1)});
    rdc(7'h0a, emin(31));
    stop_test();
  end
endmodule // fsp_pixel_grab_top_tb
`default_nettype wire
